// ### capability_map.svh
// Constants for the core capability configuration register.
// Assumes inclusion by the package and the register modules only.
//
// Behaviour
// - Bit 31 always reads one.
// - Unimplemented positions always read zero.
// - Priority width field reads binary 01.
// - Compact encoding revision reads 000.
// - Bit 17 reports microcontroller extension present.
// - Bit 16 writable, selects exception code set.
// - Availability reads 11 compact, 10 full.
// - Boot config bit loads select and availability.
// - Bits 13 and 12 read one.
// - Bits 11 and 10 read one.
// - Bit 8 reads one, flow trace.
// - Bits 6 and 5 read one.
// - Bit 3 one, bit 0 zero.
`ifndef CAPABILITY_MAP_SVH
`define CAPABILITY_MAP_SVH

// ***********************************
// Register selector and field layout
// ***********************************
`define CAP_REG_NUM            5'd16
`define CAP_REG_SEL            3'd3
`define CAP_CHAIN_BIT          31
`define CAP_PRIO_WIDTH_LSB     21
`define CAP_PRIO_WIDTH_VAL     2'b01
`define CAP_REV_LSB            18
`define CAP_REV_VAL            3'b000
`define CAP_CTRL_EXT_BIT       17
`define CAP_EXC_SEL_BIT        16
`define CAP_AVAIL_LSB          14
`define CAP_AVAIL_COMPACT      2'b11
`define CAP_AVAIL_FULL         2'b10
`define CAP_ULR_BIT            13
`define CAP_PAGE_INH_BIT       12
`define CAP_SIG_REV2_BIT       11
`define CAP_SIG_BIT            10
`define CAP_FLOW_TRACE_BIT     8
`define CAP_EXT_VEC_BIT        6
`define CAP_VEC_IRQ_BIT        5
`define CAP_SMALL_PAGE_BIT     4
`define CAP_DEV_MAP_BIT        3
`define CAP_TRACE_LOGIC_BIT    0
`define BOOT_CODE_SET_BIT      6
`define CAP_EXC_SEL_RESET      1'b0

`endif

// ### capability_pkg.sv
// Types shared by the capability register modules.
// Assumes the map header sits in the same folder.
`default_nettype none
`include "capability_map.svh"

package capability_pkg;
    typedef logic [31:0] word_t;
    typedef enum logic {
        CODE_SET_FULL,
        CODE_SET_COMPACT
    } code_set_t;
endpackage : capability_pkg

`default_nettype wire

// ### cap_strap_if.sv
// Carrier for the boot strap capture between top and strap latch.
// Assumes one clock domain.
`timescale 1ns/1ps
`default_nettype none

interface cap_strap_if;
    logic loaded;   // Strap captured since reset
    logic compact;  // Captured boot code set
    modport latch (output loaded, output compact);
    modport user  (input loaded, input compact);
endinterface : cap_strap_if

`default_nettype wire

// ### cap_strap_latch.sv
// Captures the boot code-set strap once after reset release.
// Assumes boot_config_word_zero is stable around reset release.
`timescale 1ns/1ps
`default_nettype none

`include "capability_map.svh"

module cap_strap_latch
    import capability_pkg::*;
#(
    parameter int unsigned CFG_W = 32
) (
    input  wire logic             ref_clk_i,
    input  wire logic             rst_n_i,
    input  wire logic [CFG_W-1:0] boot_config_word_zero_i,
    cap_strap_if.latch            strap
);
    // ***********************************
    // Strap capture
    // ***********************************
    // Reset loads constants only; the strap is sampled on the first edge after release
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            strap.loaded  <= 1'b0;
            strap.compact <= 1'b0;
        end else if (!strap.loaded) begin
            strap.loaded  <= 1'b1;
            strap.compact <= boot_config_word_zero_i[`BOOT_CODE_SET_BIT];
        end
    end
endmodule : cap_strap_latch

`default_nettype wire

// ### core_capability_config.sv
// Core capability configuration register, reached by coprocessor moves.
// Assumes a one-cycle move strobe with register number and select.
// Assumes the boot configuration word is settled before reset release.
// Every output comes from a flip-flop; read data is zero outside a hit.
`timescale 1ns/1ps
`default_nettype none

`include "capability_map.svh"

module core_capability_config
    import capability_pkg::*;
(
    input  wire logic        ref_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic [31:0] boot_config_word_zero_i,
    input  wire logic        move_to_i,
    input  wire logic        move_from_i,
    input  wire logic [4:0]  reg_num_i,
    input  wire logic [2:0]  reg_sel_i,
    input  wire logic [31:0] move_data_i,
    output logic      [31:0] read_data_o,
    output logic             read_valid_o,
    output logic             exception_entry_code_select_o,
    output logic             config_loaded_o
);
    // ***********************************
    // Strap capture
    // ***********************************
    // The boot code set is latched once per reset by the small module below
    cap_strap_if strap ();

    cap_strap_latch #(
        .CFG_W (32)
    ) u_strap (
        .ref_clk_i               (ref_clk_i),
        .rst_n_i                 (rst_n_i),
        .boot_config_word_zero_i (boot_config_word_zero_i),
        .strap                   (strap)
    );

    // ***********************************
    // Decode
    // ***********************************
    // Register selection; both the number and the select must match
    logic num_hit;
    logic sel_hit;
    logic hit;
    logic write_sel;
    logic read_sel;
    logic strap_now;
    assign num_hit   = (reg_num_i == `CAP_REG_NUM);
    assign sel_hit   = (reg_sel_i == `CAP_REG_SEL);
    assign hit       = num_hit && sel_hit;
    // A write before the strap is captured is dropped, so boot always sets the mode first
    assign write_sel = move_to_i && hit && strap.loaded;
    assign read_sel  = move_from_i && hit;
    // One-cycle pulse on the edge after capture; config_loaded_o marks it as done
    assign strap_now = strap.loaded && !config_loaded_o;

    // ***********************************
    // Writable state
    // ***********************************
    logic      exc_sel;
    logic      next_exc_sel;
    code_set_t avail_mode;
    code_set_t next_avail_mode;
    code_set_t strap_mode;

    // Availability follows the strap only; software writes never reach it
    assign strap_mode      = strap.compact ? CODE_SET_COMPACT : CODE_SET_FULL;
    assign next_avail_mode = strap_now ? strap_mode : avail_mode;

    // Strap load wins once; later only the select bit takes writes
    assign next_exc_sel = strap_now ? strap.compact
                        : write_sel ? move_data_i[`CAP_EXC_SEL_BIT]
                        : exc_sel;

    // Select bit; its reset value only shows until the strap lands
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            exc_sel <= `CAP_EXC_SEL_RESET;
        end else begin
            exc_sel <= next_exc_sel;
        end
    end

    // Availability mode; full set until the strap says otherwise
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            avail_mode <= CODE_SET_FULL;
        end else begin
            avail_mode <= next_avail_mode;
        end
    end

    // ***********************************
    // Reported capability fields
    // ***********************************
    // Every option is a named wire, so changing what the core reports is a one-line edit
    logic       chain_bit;
    logic [1:0] priority_width_field;
    logic [2:0] compact_encoding_revision;

    // Presence flags, one bit each, plus the two-bit code set availability field
    logic       ctrl_ext_present;
    logic [1:0] code_set_availability;
    logic       user_local_reg_present;
    logic       page_inhibit_controls_present;
    logic       signal_ext_rev2_present;
    logic       signal_ext_present;
    logic       flow_trace_present;
    logic       external_vector_ctrl_support;
    logic       vectored_irq_support;
    logic       small_page_flag;
    logic       device_memory_map_present;
    logic       trace_logic_flag;

    // A further configuration register always follows in the chain
    assign chain_bit = 1'b1;

    // Priority fields are eight bits wide; first compact encoding release
    assign priority_width_field      = `CAP_PRIO_WIDTH_VAL;
    assign compact_encoding_revision = `CAP_REV_VAL;

    // Code set options; availability is frozen at the strap, unlike the select bit
    assign ctrl_ext_present      = 1'b1;
    assign code_set_availability = (avail_mode == CODE_SET_COMPACT) ? `CAP_AVAIL_COMPACT
                                                                    : `CAP_AVAIL_FULL;

    // Extensions built into the core
    assign user_local_reg_present        = 1'b1;
    assign page_inhibit_controls_present = 1'b1;
    assign signal_ext_rev2_present       = 1'b1;
    assign signal_ext_present            = 1'b1;
    assign flow_trace_present            = 1'b1;

    // Interrupt and memory options; small pages and trace logic are absent
    assign external_vector_ctrl_support = 1'b1;
    assign vectored_irq_support         = 1'b1;
    assign small_page_flag              = 1'b0;
    assign device_memory_map_present    = 1'b1;
    assign trace_logic_flag             = 1'b0;

    // ***********************************
    // Read value
    // ***********************************
    // Place each field at its position; every other position stays zero
    word_t cap_word;
    always_comb begin
        cap_word                           = '0;
        cap_word[`CAP_CHAIN_BIT]           = chain_bit;
        cap_word[`CAP_PRIO_WIDTH_LSB +: 2] = priority_width_field;
        cap_word[`CAP_REV_LSB +: 3]        = compact_encoding_revision;
        cap_word[`CAP_CTRL_EXT_BIT]        = ctrl_ext_present;
        cap_word[`CAP_EXC_SEL_BIT]         = exc_sel;
        cap_word[`CAP_AVAIL_LSB +: 2]      = code_set_availability;
        cap_word[`CAP_ULR_BIT]             = user_local_reg_present;
        cap_word[`CAP_PAGE_INH_BIT]        = page_inhibit_controls_present;
        cap_word[`CAP_SIG_REV2_BIT]        = signal_ext_rev2_present;
        cap_word[`CAP_SIG_BIT]             = signal_ext_present;
        cap_word[`CAP_FLOW_TRACE_BIT]      = flow_trace_present;
        cap_word[`CAP_EXT_VEC_BIT]         = external_vector_ctrl_support;
        cap_word[`CAP_VEC_IRQ_BIT]         = vectored_irq_support;
        cap_word[`CAP_SMALL_PAGE_BIT]      = small_page_flag;
        cap_word[`CAP_DEV_MAP_BIT]         = device_memory_map_present;
        cap_word[`CAP_TRACE_LOGIC_BIT]     = trace_logic_flag;
    end

    // ***********************************
    // Read answer
    // ***********************************
    // A miss returns zero so a stale word never leaks to another register's read
    word_t next_read_data;
    logic  next_read_valid;
    assign next_read_data  = read_sel ? cap_word : '0;
    // Valid pulses once per taken read; a write alone never answers
    assign next_read_valid = read_sel;

    // ***********************************
    // Output registers
    // ***********************************
    // Read data stands for exactly one cycle after the taking edge
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            read_data_o <= '0;
        end else begin
            read_data_o <= next_read_data;
        end
    end

    // Valid pulse pairs with the data above
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            read_valid_o <= 1'b0;
        end else begin
            read_valid_o <= next_read_valid;
        end
    end

    // Select output mirrors the bit as it reads after this edge
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            exception_entry_code_select_o <= 1'b0;
        end else begin
            exception_entry_code_select_o <= next_exc_sel;
        end
    end

    // Loaded lags the strap capture by one edge, matching the field load
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            config_loaded_o <= 1'b0;
        end else begin
            config_loaded_o <= strap.loaded;
        end
    end
endmodule : core_capability_config

`default_nettype wire

// ### cap_cfg_asserts.sv
// Port checker for the capability register.
// Assumes binding to core_capability_config.
`timescale 1ns/1ps
`default_nettype none
module cap_cfg_asserts (
    input wire logic        ref_clk_i,
    input wire logic        rst_n_i,
    input wire logic [31:0] boot_config_word_zero_i,
    input wire logic        move_to_i,
    input wire logic        move_from_i,
    input wire logic [4:0]  reg_num_i,
    input wire logic [2:0]  reg_sel_i,
    input wire logic [31:0] move_data_i,
    input wire logic [31:0] read_data_o,
    input wire logic        read_valid_o,
    input wire logic        exception_entry_code_select_o,
    input wire logic        config_loaded_o
);
    // *****
    // Properties
    // *****
    // Only number 16 select 3 belongs to this register
    wire hit = (reg_num_i == 5'h10) && (reg_sel_i == 3'h3);
    wire sel = exception_entry_code_select_o;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    a_chain_bit_set: assert property (read_valid_o |-> read_data_o[31])
        else $error("chain bit low");
    a_unimpl_zero: assert property (read_valid_o |->
        {read_data_o[30:23], read_data_o[9], read_data_o[7], read_data_o[2:1]} == 12'h0)
        else $error("unimplemented bit set");
    a_prio_width: assert property (read_valid_o |-> read_data_o[22:21] == 2'h1)
        else $error("priority width wrong");
    a_rev_zero: assert property (read_valid_o |-> read_data_o[20:18] == 3'h0)
        else $error("revision wrong");
    a_fixed_ones: assert property (
        read_valid_o |-> &(read_data_o | ~32'h00023d68))
        else $error("fixed one missing");
    a_fixed_zeros: assert property (
        read_valid_o |-> !read_data_o[4] && !read_data_o[0])
        else $error("fixed zero set");
    a_sel_mirror: assert property (read_valid_o |-> read_data_o[16] == $past(sel))
        else $error("bit 16 differs from select");
    a_avail_field: assert property (read_valid_o && $past(config_loaded_o) |->
        read_data_o[15:14] == {1'b1, boot_config_word_zero_i[6]}) else $error("avail wrong");
    a_read_answer: assert property (move_from_i && hit |=> read_valid_o)
        else $error("read not answered");
    a_miss_quiet: assert property (!(move_from_i && hit) |=> !read_valid_o && read_data_o == 32'h0)
        else $error("miss answered");
    a_write_select: assert property (move_to_i && hit && config_loaded_o |=>
        sel == $past(move_data_i[16])) else $error("select not written");
    a_select_hold: assert property (
        config_loaded_o && !(move_to_i && hit) |=> $stable(sel))
        else $error("select changed");
    a_strap_load: assert property (
        $rose(config_loaded_o) |-> sel == boot_config_word_zero_i[6])
        else $error("strap not loaded");
    c_read: cover property (move_from_i && hit);
    c_write: cover property (move_to_i && hit && config_loaded_o);
    c_compact: cover property ($rose(config_loaded_o) && sel);
endmodule : cap_cfg_asserts
bind core_capability_config cap_cfg_asserts u_cap_cfg_asserts (.*);
`default_nettype wire

// ### core_capability_config_tb.sv
// Self-checking bench for the capability register.
// Assumes design and checker files are compiled first.
`timescale 1ns/1ps
`default_nettype none
module core_capability_config_tb import capability_pkg::*;;
    // *****
    // Stimulus and checks
    // *****
    logic       ref_clk_i, rst_n_i, move_to_i, move_from_i, sel_o, loaded_o, valid_o;
    logic [4:0] reg_num_i;
    logic [2:0] reg_sel_i;
    word_t      boot_i, data_i, rdata_o;
    int         fail_count, tests_run;
    core_capability_config u_core_capability_config (
        .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .boot_config_word_zero_i(boot_i),
        .move_to_i(move_to_i), .move_from_i(move_from_i), .reg_num_i(reg_num_i),
        .reg_sel_i(reg_sel_i), .move_data_i(data_i), .read_data_o(rdata_o),
        .read_valid_o(valid_o), .exception_entry_code_select_o(sel_o),
        .config_loaded_o(loaded_o));
    // Expected word; only bits 16 and 14 follow the strap
    function automatic word_t word(input logic c);
        return 32'h80223d68 | (c ? 32'h0001c000 : 32'h00008000);
    endfunction : word
    task automatic check(input logic [33:0] got, input logic [33:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    // One move, answer judged in the cycle it stands, then realign to an edge
    task automatic xfer(input logic rd, wr, input logic [2:0] s, input word_t wd,
                        input logic [33:0] exp);
        move_from_i <= rd;
        move_to_i   <= wr;
        reg_sel_i   <= s;
        data_i      <= wd;
        @(posedge ref_clk_i);
        move_from_i <= 1'b0;
        move_to_i   <= 1'b0;
        #1 check({valid_o, sel_o, rdata_o}, exp);
        @(posedge ref_clk_i);
    endtask : xfer
    task automatic t_boot(input logic c);
        boot_i  <= {25'h0, c, 6'h0};
        rst_n_i <= 1'b0;
        repeat (9) @(posedge ref_clk_i);
        #1 check({valid_o, loaded_o, rdata_o}, 34'h0);
        check({33'h0, sel_o}, 34'h0);
        @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        @(posedge ref_clk_i);
        move_to_i <= 1'b1;
        data_i    <= {15'h0, ~c, 16'h0};
        #1 check({valid_o, loaded_o, 31'h0, sel_o}, 34'h0);
        @(posedge ref_clk_i);
        move_to_i <= 1'b0;
        #1 check({valid_o, loaded_o, 31'h0, sel_o}, {2'b01, 31'h0, c});
        @(posedge ref_clk_i);
        xfer(1'b1, 1'b0, 3'h3, 32'h0, {1'b1, c, word(c)});
        $display("boot strap %0b done", c);
    endtask : t_boot
    // Flip every bit, then read and write in one cycle
    task automatic t_write(input logic c);
        xfer(1'b0, 1'b1, 3'h3, ~word(c), {1'b0, ~c, 32'h0});
        xfer(1'b1, 1'b1, 3'h3, word(c), {1'b1, c, word(c) ^ 32'h00010000});
        xfer(1'b1, 1'b0, 3'h3, 32'h0, {1'b1, c, word(c)});
        $display("write strap %0b done", c);
    endtask : t_write
    task automatic t_miss(input logic c);
        xfer(1'b1, 1'b0, 3'h2, 32'h0, {1'b0, c, 32'h0});
        xfer(1'b0, 1'b1, 3'h2, ~word(c), {1'b0, c, 32'h0});
        xfer(1'b1, 1'b0, 3'h3, 32'h0, {1'b1, c, word(c)});
        $display("miss done");
    endtask : t_miss
    task automatic summarize;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : summarize
    initial begin
        {ref_clk_i, rst_n_i, move_to_i, move_from_i, fail_count, tests_run} = '0;
        {reg_num_i, reg_sel_i, boot_i, data_i} = {5'h10, 3'h3, 64'h0};
        forever #25 ref_clk_i = ~ref_clk_i;
    end
    // Whole run is well under a thousand cycles
    initial begin
        #100us fail_count++;
        summarize();
    end
    initial begin
        @(posedge ref_clk_i);
        t_boot(1'b1);
        t_write(1'b1);
        t_miss(1'b1);
        t_boot(1'b0);
        t_write(1'b0);
        summarize();
    end
endmodule : core_capability_config_tb
`default_nettype wire
